//--- inc/hdgc_consts.vh
// Constants for the health-data general command handler.
// Assumes inclusion by bare name from the rtl files.
`ifndef HDGC_CONSTS_VH
`define HDGC_CONSTS_VH
`define HDGC_DIR_BIT 0
`define HDGC_IDX_HI 7
`define HDGC_IDX_LO 1
`define HDGC_ARG1_HI 15
`define HDGC_ARG1_LO 8
`define HDGC_ARG2_HI 23
`define HDGC_ARG2_LO 16
`define HDGC_ARG3_HI 31
`define HDGC_ARG3_LO 24
`define HDGC_IDX_GET 7'h10
`define HDGC_IDX_PRELOAD 7'h08
`define HDGC_RSV_GET 24'h000000
`define HDGC_BLOCK_LAST 9'h1FF
`define HDGC_B_FLASHID_LO 9'h000
`define HDGC_B_FLASHID_HI 9'h008
`define HDGC_B_CTLVER_LO 9'h009
`define HDGC_B_CTLVER_HI 9'h00A
`define HDGC_B_CECNT 9'h00E
`define HDGC_B_BBMAX_LO 9'h010
`define HDGC_B_BBMAX_HI 9'h011
`define HDGC_B_GOOD_LO 9'h040
`define HDGC_B_GOOD_HI 9'h041
`define HDGC_B_ERASE_LO 9'h050
`define HDGC_B_ERASE_HI 9'h053
`define HDGC_B_MINER_LO 9'h064
`define HDGC_B_MINER_HI 9'h065
`define HDGC_B_MAXER_LO 9'h066
`define HDGC_B_MAXER_HI 9'h067
`define HDGC_B_REFR_LO 9'h0A0
`define HDGC_B_REFR_HI 9'h0A1
`define HDGC_B_DIEBB_LO 9'h0B8
`define HDGC_B_DIEBB_HI 9'h0D7
`define HDGC_FIFO_DEPTH 32
`define HDGC_FIFO_AW 5
`define HDGC_ARG_BITS 6'h20
`endif

//--- rtl/hdgc_fifo.v
// Synchronous FIFO with valid/ready on both sides and registered read data.
// Assumes one clock, synchronous active-low reset and a shared clock enable.
`timescale 1ns/100ps
`default_nettype none
module hdgc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire mclk, // System clock.
    input wire resetn, // Synchronous reset, active low.
    input wire clkEn, // Clock enable.
    input wire [WIDTH-1:0] inData, // Write data.
    input wire inValid, // Write request.
    output wire inReady, // Space available.
    output reg [WIDTH-1:0] outData, // Registered read data.
    output reg outValid, // Read data valid.
    input wire outReady // Consumer takes data.
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wrPtr_r;
    reg [AW:0] rdPtr_r;
    wire [AW:0] used;
    wire memEmpty;
    wire doWrite;
    wire doRead;

    // Full and empty come straight from the pointer difference.
    assign used = wrPtr_r - rdPtr_r;
    assign memEmpty = (used == {(AW+1){1'b0}});
    assign inReady = (used != DEPTH[AW:0]) || (DEPTH[AW] == 1'b0 && used[AW]);
    assign doWrite = inValid && inReady;
    assign doRead = !memEmpty && (!outValid || outReady);

    // Storage array, written without reset.
    always @(posedge mclk)
    begin
        if (clkEn && doWrite)
            mem[wrPtr_r[AW-1:0]] <= inData;
    end

    // Pointers and the output register stage.
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            wrPtr_r <= {(AW+1){1'b0}};
            rdPtr_r <= {(AW+1){1'b0}};
            outData <= {WIDTH{1'b0}};
            outValid <= 1'b0;
        end
        else if (clkEn)
        begin
            if (doWrite)
                wrPtr_r <= wrPtr_r + 1'b1;
            if (doRead)
            begin
                outData <= mem[rdPtr_r[AW-1:0]];
                rdPtr_r <= rdPtr_r + 1'b1;
                outValid <= 1'b1;
            end
            else if (outReady)
                outValid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- rtl/hdgc_handler.v
// Card-side handler for the health-data general command: decodes the argument,
// tracks pre-load then get, and streams a 512-byte health block through a FIFO.
// Assumes the command layer delivers a decoded argument with a strobe; the
// link clock is only sampled to pace the byte stream out.
//
// Summary of operation
// R1: Argument bit 0 set means read mode, clear means write mode.
// R2: Argument bits 7..1 hold the seven-bit function index.
// R3: Read mode with index 0x10 returns the health block.
// R4: Write mode with index 0x08 pre-loads the health information.
// R5: Bytes one to three of the argument are function arguments one to three.
// R6: Host sends the pre-load first, then the get command.
// R7: Pre-load carries zero reserved bits and yields no read data; the handler accepts a pre-load whatever bits 8..31 hold.
// R8: Get command has argument bits 8..31 zero.
// R9: Bytes 0-8 flash id, 9-10 controller version, 14 CE count, 16-17 bad max.
// R10: Bytes 64-65 good-block rate, bytes 80-83 total erase count.
// R11: Bytes 100-101 low minimum erase, 102-103 low maximum erase count.
// R12: Bytes 160-161 refresh count, 184-215 per-die bad blocks, rest reserved.
// R13: Reserved bytes in the returned block read as zero.
`timescale 1ns/100ps
`default_nettype none
`include "hdgc_consts.vh"
module hdgc_handler (
    input wire mclk, // System clock, 40 MHz.
    input wire resetn, // Synchronous reset, active low.
    input wire clkEn, // Clock enable; low freezes all state.
    input wire cmdValid, // General command argument strobe.
    input wire [31:0] cmdArg, // General command argument.
    output reg cmdAccept, // Command was recognised, one-cycle pulse.
    output reg cmdReject, // Command was not recognised, one-cycle pulse.
    output reg [7:0] funcArg1, // Latched function argument one.
    output reg [7:0] funcArg2, // Latched function argument two.
    output reg [7:0] funcArg3, // Latched function argument three.
    output reg preloaded, // Health data prepared for reading.
    output reg blockBusy, // Health block being sent.
    input wire linkClk, // Link clock from the host, asynchronous.
    output wire [7:0] dataOut, // Health block byte, registered.
    output wire dataValid, // Byte on dataOut is valid.
    input wire dataReady, // Consumer takes the byte.
    input wire [71:0] flashId, // Flash identifier.
    input wire [15:0] ctlVersion, // Controller version.
    input wire [7:0] ceCount, // Chip-enable count.
    input wire [15:0] badMax, // Maximum bad-block replacement count.
    input wire [15:0] goodRate, // Good-block rate in percent.
    input wire [31:0] eraseTotal, // Total erase count.
    input wire [15:0] eraseMinLow, // Low-part minimum erase count.
    input wire [15:0] eraseMaxLow, // Low-part maximum erase count.
    input wire [15:0] refreshTotal, // Total refresh count.
    input wire [255:0] dieBadBlocks // Per-die bad-block counts, byte 184 low.
);
    // Handler states: idle waits for commands, fill writes the block into the FIFO.
    localparam ST_IDLE = 2'b00;
    localparam ST_FILL = 2'b01;

    // Sequencing state and the offset of the next byte to build.
    reg [1:0] state_r;
    reg [8:0] byteIdx_r;
    // Snapshot of the health counters, frozen at pre-load so one read sees one set.
    reg [71:0] snapId_r;
    reg [15:0] snapVer_r;
    reg [7:0] snapCe_r;
    reg [15:0] snapBad_r;
    reg [15:0] snapGood_r;
    reg [31:0] snapErase_r;
    reg [15:0] snapMin_r;
    reg [15:0] snapMax_r;
    reg [15:0] snapRefr_r;
    reg [255:0] snapDie_r;

    // Link clock synchroniser stages and edge history.
    reg lkSync1_r;
    reg lkSync2_r;
    reg lkPrev_r;
    // Byte offered to the FIFO and the count of bytes the FIFO holds.
    reg [7:0] fillByte;
    reg [`HDGC_FIFO_AW:0] holdCnt_r;
    wire holdInc;
    wire holdDec;

    // Decoded command fields and stream handshakes.
    wire isRead;
    wire [6:0] funcIdx;
    wire isGet;
    wire isPreload;
    wire fillReady;
    wire fillValid;
    wire outReady;
    wire lkRise;
    wire [8:0] off;
    // One hit line per field of the block.
    wire hitId;
    wire hitVer;
    wire hitCe;
    wire hitBad;
    wire hitGood;
    wire hitErase;
    wire hitMin;
    wire hitMax;
    wire hitRefr;
    wire hitDie;

    // Argument field decode.
    assign isRead = cmdArg[`HDGC_DIR_BIT]; // R1
    assign funcIdx = cmdArg[`HDGC_IDX_HI:`HDGC_IDX_LO]; // R2
    // A get needs a prior pre-load and a zero reserved field.
    assign isGet = isRead && funcIdx == `HDGC_IDX_GET && preloaded
        && cmdArg[`HDGC_ARG3_HI:`HDGC_ARG1_LO] == `HDGC_RSV_GET; // R3 R6 R8
    assign isPreload = !isRead && funcIdx == `HDGC_IDX_PRELOAD; // R4

    // The FIFO is offered a byte on every cycle of the fill state.
    assign fillValid = (state_r == ST_FILL);

    // Link clock sampled twice, then edge detected to pace the byte stream.
    assign lkRise = lkSync2_r && !lkPrev_r;
    assign outReady = dataReady && lkRise;

    // Occupancy moves on each byte written into and each byte taken out of the FIFO.
    assign holdInc = fillValid && fillReady;
    assign holdDec = dataValid && outReady;

    // Field hits by byte offset; every offset without a hit is reserved.
    assign off = byteIdx_r;
    assign hitId = (off <= `HDGC_B_FLASHID_HI); // R9
    assign hitVer = (off >= `HDGC_B_CTLVER_LO) && (off <= `HDGC_B_CTLVER_HI); // R9
    assign hitCe = (off == `HDGC_B_CECNT); // R9
    assign hitBad = (off == `HDGC_B_BBMAX_LO) || (off == `HDGC_B_BBMAX_HI); // R9
    assign hitGood = (off == `HDGC_B_GOOD_LO) || (off == `HDGC_B_GOOD_HI); // R10
    assign hitErase = (off >= `HDGC_B_ERASE_LO) && (off <= `HDGC_B_ERASE_HI); // R10
    assign hitMin = (off == `HDGC_B_MINER_LO) || (off == `HDGC_B_MINER_HI); // R11
    assign hitMax = (off == `HDGC_B_MAXER_LO) || (off == `HDGC_B_MAXER_HI); // R11
    assign hitRefr = (off == `HDGC_B_REFR_LO) || (off == `HDGC_B_REFR_HI); // R12
    assign hitDie = (off >= `HDGC_B_DIEBB_LO) && (off <= `HDGC_B_DIEBB_HI); // R12

    // Byte selection from the snapshot; multi-byte fields go out low byte first.
    always @*
    begin
        fillByte = 8'h00; // R13
        if (hitId)
            fillByte = snapId_r[off[3:0]*8 +: 8]; // R9
        else if (hitVer)
            fillByte = snapVer_r[(off - `HDGC_B_CTLVER_LO)*8 +: 8]; // R9
        else if (hitCe)
            fillByte = snapCe_r; // R9
        else if (hitBad)
            fillByte = snapBad_r[off[0]*8 +: 8]; // R9
        else if (hitGood)
            fillByte = snapGood_r[off[0]*8 +: 8]; // R10
        else if (hitErase)
            fillByte = snapErase_r[off[1:0]*8 +: 8]; // R10
        else if (hitMin)
            fillByte = snapMin_r[off[0]*8 +: 8]; // R11
        else if (hitMax)
            fillByte = snapMax_r[off[0]*8 +: 8]; // R11
        else if (hitRefr)
            fillByte = snapRefr_r[off[0]*8 +: 8]; // R12
        else if (hitDie)
            fillByte = snapDie_r[(off - `HDGC_B_DIEBB_LO)*8 +: 8]; // R12
    end

    // Link clock synchroniser and edge history; only the second stage feeds the
    // edge detector, and all stages start low like the idle link clock.
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            lkSync1_r <= 1'b0;
            lkSync2_r <= 1'b0;
            lkPrev_r <= 1'b0;
        end
        else if (clkEn)
        begin
            lkSync1_r <= linkClk;
            lkSync2_r <= lkSync1_r;
            lkPrev_r <= lkSync2_r;
        end
    end

    // Bytes held by the FIFO, its output register included. Busy follows this
    // count rather than dataValid, because the FIFO can hold a byte for a cycle
    // before its output register shows it.
    always @(posedge mclk)
    begin
        if (!resetn)
            holdCnt_r <= {(`HDGC_FIFO_AW+1){1'b0}};
        else if (clkEn)
        begin
            if (holdInc && !holdDec)
                holdCnt_r <= holdCnt_r + 1'b1;
            else if (holdDec && !holdInc)
                holdCnt_r <= holdCnt_r - 1'b1;
        end
    end

    // Command handling, snapshot on pre-load and block fill sequencing.
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            state_r <= ST_IDLE;
            byteIdx_r <= 9'h000;
            cmdAccept <= 1'b0;
            cmdReject <= 1'b0;
            funcArg1 <= 8'h00;
            funcArg2 <= 8'h00;
            funcArg3 <= 8'h00;
            preloaded <= 1'b0;
            blockBusy <= 1'b0;
            snapId_r <= 72'h0;
            snapVer_r <= 16'h0000;
            snapCe_r <= 8'h00;
            snapBad_r <= 16'h0000;
            snapGood_r <= 16'h0000;
            snapErase_r <= 32'h00000000;
            snapMin_r <= 16'h0000;
            snapMax_r <= 16'h0000;
            snapRefr_r <= 16'h0000;
            snapDie_r <= 256'h0;
        end
        else if (clkEn)
        begin
            // Answers are one-cycle pulses.
            cmdAccept <= 1'b0;
            cmdReject <= 1'b0;
            // A command seen in idle is decoded and its argument bytes latched.
            if (cmdValid && state_r == ST_IDLE)
            begin
                funcArg1 <= cmdArg[`HDGC_ARG1_HI:`HDGC_ARG1_LO]; // R5
                funcArg2 <= cmdArg[`HDGC_ARG2_HI:`HDGC_ARG2_LO]; // R5
                funcArg3 <= cmdArg[`HDGC_ARG3_HI:`HDGC_ARG3_LO]; // R5
                if (isPreload)
                begin
                    // Pre-load only freezes the counters; no read data follow.
                    cmdAccept <= 1'b1; // R7
                    preloaded <= 1'b1;
                    snapId_r <= flashId;
                    snapVer_r <= ctlVersion;
                    snapCe_r <= ceCount;
                    snapBad_r <= badMax;
                    snapGood_r <= goodRate;
                    snapErase_r <= eraseTotal;
                    snapMin_r <= eraseMinLow;
                    snapMax_r <= eraseMaxLow;
                    snapRefr_r <= refreshTotal;
                    snapDie_r <= dieBadBlocks;
                end
                // A get needs an earlier pre-load and starts the fill at offset zero.
                else if (isGet)
                begin
                    cmdAccept <= 1'b1;
                    preloaded <= 1'b0; // R6
                    blockBusy <= 1'b1;
                    byteIdx_r <= 9'h000;
                    state_r <= ST_FILL; // R3
                end
                // Wrong direction, unknown index, or a get that is not allowed.
                else
                    cmdReject <= 1'b1;
            end
            // While the block is being filled every command is refused.
            else if (cmdValid)
                cmdReject <= 1'b1;
            case (state_r)
                ST_IDLE:
                begin
                    // Busy drops once the FIFO and its output register are empty.
                    if (holdCnt_r == {(`HDGC_FIFO_AW+1){1'b0}} && !(cmdValid && isGet))
                        blockBusy <= 1'b0;
                end
                ST_FILL:
                begin
                    // One byte per cycle while the FIFO has room; the last hands over to the drain.
                    if (fillReady)
                    begin
                        byteIdx_r <= byteIdx_r + 9'h001;
                        if (byteIdx_r == `HDGC_BLOCK_LAST)
                            state_r <= ST_IDLE;
                    end
                end
                default:
                    // An unused code falls back to idle.
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Byte buffer between the block builder and the link-paced consumer.
    // Its output byte is released on a link clock rise only while the host is ready.
    hdgc_fifo #(
        .WIDTH(8),
        .DEPTH(`HDGC_FIFO_DEPTH),
        .AW(`HDGC_FIFO_AW)
    ) u_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .clkEn(clkEn),
        .inData(fillByte),
        .inValid(fillValid),
        .inReady(fillReady),
        .outData(dataOut),
        .outValid(dataValid),
        .outReady(outReady)
    );
endmodule
`default_nettype wire

//--- verification/hdgc_handler_properties.sv
// Assertions on the health handler's command and byte ports.
// Assumes a bind into hdgc_handler; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module hdgc_handler_properties (
    input wire logic mclk, // Clock.
    input wire logic resetn, // Reset, active low.
    input wire logic clkEn, // Clock enable.
    input wire logic cmdValid, // Command strobe.
    input wire logic [31:0] cmdArg, // Argument.
    input wire logic cmdAccept, // Accept pulse.
    input wire logic cmdReject, // Reject pulse.
    input wire logic [7:0] funcArg1, // Argument one.
    input wire logic [7:0] funcArg2, // Argument two.
    input wire logic [7:0] funcArg3, // Argument three.
    input wire logic preloaded, // Pre-load done.
    input wire logic blockBusy, // Block in flight.
    input wire logic [7:0] dataOut, // Byte out.
    input wire logic dataValid, // Byte valid.
    input wire logic dataReady // Byte taken.
);
    // All checks run on the system clock and rest during reset.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Decoded command qualifiers.
    wire take = clkEn && cmdValid;
    wire isGet = cmdArg[7:0] == 8'h21;
    wire isPre = cmdArg[7:0] == 8'h10;
    // Command decode and answers.
    a_preload_accept: assert property (take && !blockBusy && isPre |=> cmdAccept && preloaded)
        else $error("pre-load not accepted");
    a_preload_nodata: assert property (take && !blockBusy && isPre |=> !dataValid [*3])
        else $error("data after pre-load");
    a_get_accept: assert property (take && !blockBusy && preloaded && cmdArg == 32'h21 |=> cmdAccept && blockBusy && !preloaded)
        else $error("get not accepted");
    a_get_unloaded: assert property (take && !blockBusy && !preloaded && isGet |=> cmdReject && !blockBusy)
        else $error("get without pre-load taken");
    a_get_reserved: assert property (take && isGet && cmdArg[31:8] != 24'h000000 |=> cmdReject)
        else $error("get with reserved bits taken");
    a_index_decode: assert property (take && !isPre && !isGet |=> cmdReject && !cmdAccept)
        else $error("unknown command taken");
    a_fill_refuse: assert property (take && blockBusy && cmdAccept && !preloaded |=> cmdReject)
        else $error("command taken while filling");
    a_args_latch: assert property (take && !blockBusy |=> funcArg1 == $past(cmdArg[15:8])
        && funcArg2 == $past(cmdArg[23:16]) && funcArg3 == $past(cmdArg[31:24]))
        else $error("function arguments wrong");
    a_quiet_idle: assert property (clkEn && !cmdValid |=> !cmdAccept && !cmdReject)
        else $error("answer without command");
    a_byte_hold: assert property (clkEn && dataValid && !dataReady |=> dataValid && $stable(dataOut))
        else $error("byte changed while stalled");
    // Main scenarios reached.
    c_preload: cover property (take && isPre ##1 cmdAccept);
    c_get: cover property (take && isGet ##1 cmdAccept);
    c_stall: cover property (dataValid && !dataReady);
endmodule
bind hdgc_handler hdgc_handler_properties chk (.mclk, .resetn, .clkEn, .cmdValid, .cmdArg, .cmdAccept,
    .cmdReject, .funcArg1, .funcArg2, .funcArg3, .preloaded, .blockBusy, .dataOut, .dataValid, .dataReady);
`default_nettype wire

//--- verification/hdgc_host_model.sv
// Host side of the byte stream: link clock and byte capture.
// Assumes the handler takes one byte per link clock rise while ready.
`timescale 1ns/100ps
`default_nettype none
module hdgc_host_model (
    input wire logic mclk, // System clock, gives frame start phase.
    input wire logic [7:0] dataOut, // Byte from the card.
    input wire logic dataValid, // Byte valid.
    output logic linkClk, // Link clock, still outside frames.
    output logic dataReady // Host takes bytes.
);
    logic [7:0] got [0:511];
    int nGot;
    // The link clock idles low and nothing is taken between frames.
    initial
    begin
        linkClk = 1'b0;
        dataReady = 1'b0;
        nGot = 0;
    end
    // One frame of 200 ns periods; the host stalls for a span of periods.
    task automatic run_frame(input int stallAt, input int stallLen);
        int p;
        p = 0;
        nGot = 0;
        @(posedge mclk);
        #1;
        while (nGot < 512 && p < 2000)
        begin
            dataReady = !(p >= stallAt && p < stallAt + stallLen);
            linkClk = 1'b1;
            if (dataReady && dataValid)
            begin
                got[nGot] = dataOut;
                nGot++;
            end
            #100 linkClk = 1'b0;
            #100 p++;
        end
        dataReady = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the health-data command handler.
// Assumes the host model paces and captures the returned block.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic clkEn = 1'b1;
    logic cmdValid = 1'b0;
    logic [31:0] cmdArg = 32'h00000000;
    logic [71:0] flashId = 72'h191817161514131211;
    logic [15:0] ctlVersion = 16'h2B2A;
    logic [7:0] ceCount = 8'h3C;
    logic [15:0] badMax = 16'h4E4D;
    logic [15:0] goodRate = 16'h6463;
    logic [31:0] eraseTotal = 32'h83828180;
    logic [15:0] eraseMinLow = 16'h6766;
    logic [15:0] eraseMaxLow = 16'h6968;
    logic [15:0] refreshTotal = 16'hA1A0;
    logic [255:0] dieBadBlocks = {8{32'hD7C3B8E1}};
    wire cmdAccept, cmdReject, preloaded, blockBusy, linkClk, dataValid, dataReady;
    wire [7:0] funcArg1, funcArg2, funcArg3, dataOut;
    logic [7:0] e [0:511];
    int mismatches = 0;
    int totalChecks = 0;
    hdgc_handler dut (.mclk, .resetn, .clkEn, .cmdValid, .cmdArg, .cmdAccept, .cmdReject, .funcArg1,
        .funcArg2, .funcArg3, .preloaded, .blockBusy, .linkClk, .dataOut, .dataValid, .dataReady,
        .flashId, .ctlVersion, .ceCount, .badMax, .goodRate, .eraseTotal, .eraseMinLow, .eraseMaxLow,
        .refreshTotal, .dieBadBlocks);
    hdgc_host_model host (.mclk, .dataOut, .dataValid, .linkClk, .dataReady);
    // Clock of 25 ns.
    always #12.5 mclk = ~mclk;
    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        totalChecks++;
        if (seen !== want)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic finalReport;
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Issues one command and judges the answer; hold keeps the strobe up for a back-to-back one.
    task automatic send(input logic [31:0] arg, input logic acc, input logic hold);
        cmdValid = 1'b1;
        cmdArg = arg;
        @(posedge mclk);
        #1;
        check(cmdAccept, acc);
        check(cmdReject, !acc);
        if (!hold)
        begin
            // Let one edge pass with the strobe low before the next command.
            cmdValid = 1'b0;
            @(posedge mclk);
            #1;
        end
    endtask
    // Unknown commands and a get before any pre-load are refused.
    task automatic t_refuse;
        send(32'h00000021, 1'b0, 1'b0);
        send(32'hC3B2A120, 1'b0, 1'b0);
        check({funcArg3, funcArg2, funcArg1}, 24'hC3B2A1);
        send(32'h00000011, 1'b0, 1'b0);
        check(preloaded, 1'b0);
        // A pre-load offered while the clock enable is low is ignored.
        clkEn = 1'b0;
        cmdValid = 1'b1;
        cmdArg = 32'h00000010;
        @(posedge mclk);
        #1;
        cmdValid = 1'b0;
        clkEn = 1'b1;
        check({cmdAccept, cmdReject, preloaded}, 3'h0);
        @(posedge mclk);
        #1;
        check({cmdAccept, cmdReject, preloaded}, 3'h0);
    endtask
    // Pre-load latches the argument bytes and returns no data.
    task automatic t_preload;
        send(32'h00000010, 1'b1, 1'b0);
        check({funcArg3, funcArg2, funcArg1}, 24'h000000);
        check(preloaded, 1'b1);
        repeat (8)
        begin
            @(posedge mclk);
            #1 check(dataValid, 1'b0);
        end
    endtask
    // Get with reserved bits is refused, a clean get streams the block.
    task automatic t_get;
        int n;
        send(32'h00000121, 1'b0, 1'b0);
        check(preloaded, 1'b1);
        send(32'h00000021, 1'b1, 1'b1);
        check(blockBusy, 1'b1);
        send(32'h00000010, 1'b0, 1'b0);
        for (int i = 0; i < 512; i++)
            e[i] = 8'h00;
        for (int i = 0; i < 9; i++)
            e[i] = flashId[8*i+:8];
        {e[10], e[9]} = ctlVersion;
        e[14] = ceCount;
        {e[17], e[16]} = badMax;
        {e[65], e[64]} = goodRate;
        {e[83], e[82], e[81], e[80]} = eraseTotal;
        {e[101], e[100]} = eraseMinLow;
        {e[103], e[102]} = eraseMaxLow;
        {e[161], e[160]} = refreshTotal;
        for (int i = 0; i < 32; i++)
            e[184+i] = dieBadBlocks[8*i+:8];
        n = 0;
        while (dataValid !== 1'b1 && n < 50)
        begin
            @(posedge mclk);
            n++;
        end
        host.run_frame(40, 40);
        check(host.nGot, 512);
        for (int i = 0; i < 512; i++)
            check(host.got[i], e[i]);
        repeat (10) @(posedge mclk);
        #1 check({blockBusy, dataValid, preloaded}, 3'h0);
    endtask
    // Watchdog against a hang.
    initial
    begin
        #400000;
        mismatches++;
        finalReport;
    end
    // Main sequence.
    initial
    begin
        repeat (2) @(posedge mclk);
        #1 resetn = 1'b1;
        check({cmdAccept, cmdReject, preloaded, blockBusy, dataValid}, 5'h00);
        t_refuse;
        t_preload;
        t_get;
        finalReport;
    end
endmodule
`default_nettype wire
